// file: csm_clock_manager.sv
// Spread-spectrum clock manager with Wishbone control registers
`timescale 1ns/1ps
// Notes on behaviour
// - Spreading modulates the period of the four phase outputs directly.
// - Modulation starts right after lock rises, never before lock.
// - Spread enable pin may toggle anytime, switching spreading without reconfiguration.
// - Four settings walk the period within plus or minus one to four taps.
// - Low or high frequency mode selected by software.
// - High frequency mode silences doubled outputs and the 90/270 phases.
// - Lock rises only after every enabled circuit has settled.
// - Manager reset returns lock and spreading to their initial condition.
// - Four phase outputs sit a quarter period apart.
module csm_clock_manager #(
	parameter int ADR_W = 8
) (
	// Clock, enable and reset
	input wire logic sys_clk_i,
	input wire logic ce_i,
	input wire logic rst_n_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Pins from user logic
	input wire logic spread_enable_in_i,
	input wire logic mgr_reset_i,
	// Generated clocks and status
	output logic phase0_clock_out_o,
	output logic phase90_clock_out_o,
	output logic phase180_clock_out_o,
	output logic phase270_clock_out_o,
	output logic double_rate_clock_out_o,
	output logic double_rate_inverted_clock_out_o,
	output logic divided_clock_out_o,
	output logic synthesized_clock_out_o,
	output logic synthesized_inverted_clock_out_o,
	output logic locked_o
);
	// Pin synchronisers
	logic spread_meta;
	logic spread_sync;
	logic mrst_meta;
	logic mrst_sync;
	// Bus and register state
	logic ack;
	logic next_ack;
	logic [31:0] rdata;
	logic [31:0] next_rdata;
	csm_pkg::csm_ctrl_t ctrl;
	csm_pkg::csm_ctrl_t next_ctrl;
	logic [7:0] div_ratio;
	logic [7:0] next_div_ratio;
	logic [15:0] fx_step;
	logic [15:0] next_fx_step;
	// Lock sequencer
	csm_pkg::csm_state_t state;
	csm_pkg::csm_state_t next_state;
	logic [15:0] lock_cnt;
	logic [15:0] next_lock_cnt;
	// Clock generation
	logic [7:0] cnt;
	logic [7:0] next_cnt;
	logic signed [3:0] offset;
	logic signed [3:0] next_offset;
	logic dir_up;
	logic next_dir_up;
	logic [7:0] div_cnt;
	logic [7:0] next_div_cnt;
	logic [15:0] fx_acc;
	logic [15:0] next_fx_acc;
	csm_pkg::csm_clk_t clks;
	csm_pkg::csm_clk_t next_clks;
	// Decoded terms
	logic bus_req;
	logic wr_ctrl;
	logic restart;
	logic locked;
	logic spread_active;
	logic [7:0] period;
	logic [7:0] half;
	logic [7:0] quarter;
	logic period_end;
	logic signed [3:0] taps;
	logic rd_req;
	logic wr_div;
	logic wr_fx;
	logic spread_hold;

	function automatic logic hit(input logic [ADR_W-1:0] adr, input logic [7:0] ofs);
		// Upper address bits must be zero, so aliases read as unmapped
		hit = (adr == ADR_W'(ofs));
	endfunction

	// Manager reset sync starts asserted, so lock waits for the pin to settle
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			spread_meta <= 1'b0;
			spread_sync <= 1'b0;
			mrst_meta <= 1'b1;
			mrst_sync <= 1'b1;
		end else if (ce_i) begin
			spread_meta <= spread_enable_in_i;
			spread_sync <= spread_meta;
			mrst_meta <= mgr_reset_i;
			mrst_sync <= mrst_meta;
		end
	end

	// Register bus
	assign bus_req = wb_cyc_i && wb_stb_i && !ack;
	assign wr_ctrl = bus_req && wb_we_i && wb_sel_i[0] && hit(wb_adr_i, csm_pkg::CTRL_OFS);
	assign locked = (state == csm_pkg::ST_LOCK);
	// Writes land at the taking edge; ack rises at that same edge, nothing refused
	assign rd_req = bus_req && !wb_we_i;
	assign wr_div = bus_req && wb_we_i && wb_sel_i[0] && hit(wb_adr_i, csm_pkg::DIV_OFS);
	assign wr_fx = bus_req && wb_we_i && hit(wb_adr_i, csm_pkg::FX_OFS);

	always_comb begin
		next_ack = bus_req;
		next_rdata = rdata;
		next_ctrl = ctrl;
		next_div_ratio = div_ratio;
		next_fx_step = fx_step;
		if (wr_ctrl) begin
			next_ctrl = wb_dat_i[csm_pkg::CTRL_SPREAD_LSB+1:0];
		end
		if (wr_div) begin
			next_div_ratio = (wb_dat_i[7:1] == 7'h00) ? 8'h02 : wb_dat_i[7:0];
		end
		if (wr_fx) begin
			if (wb_sel_i[0]) begin
				next_fx_step[7:0] = wb_dat_i[7:0];
			end
			if (wb_sel_i[1]) begin
				next_fx_step[15:8] = wb_dat_i[15:8];
			end
		end
		if (rd_req) begin
			next_rdata = 32'h0000_0000;
			if (hit(wb_adr_i, csm_pkg::CTRL_OFS)) begin
				next_rdata[3:0] = ctrl;
			end else if (hit(wb_adr_i, csm_pkg::STAT_OFS)) begin
				next_rdata[csm_pkg::STAT_LOCK_BIT] = locked;
				next_rdata[csm_pkg::STAT_SPREAD_BIT] = spread_active;
				next_rdata[csm_pkg::STAT_HF_BIT] = ctrl.high_freq;
				next_rdata[csm_pkg::STAT_OFFSET_LSB+3:csm_pkg::STAT_OFFSET_LSB] = offset;
			end else if (hit(wb_adr_i, csm_pkg::DIV_OFS)) begin
				next_rdata[7:0] = div_ratio;
			end else if (hit(wb_adr_i, csm_pkg::FX_OFS)) begin
				next_rdata[15:0] = fx_step;
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ack <= 1'b0;
			rdata <= 32'h0000_0000;
			ctrl <= csm_pkg::CTRL_RST;
			div_ratio <= csm_pkg::DIV_RST;
			fx_step <= csm_pkg::FX_RST;
		end else if (ce_i) begin
			ack <= next_ack;
			rdata <= next_rdata;
			ctrl <= next_ctrl;
			div_ratio <= next_div_ratio;
			fx_step <= next_fx_step;
		end
	end

	// Lock sequencer; a mode change relocks because ranges differ per mode
	assign restart = mrst_sync || !ctrl.run
		|| (wr_ctrl && (wb_dat_i[csm_pkg::CTRL_HF_BIT] != ctrl.high_freq));

	always_comb begin
		next_state = state;
		next_lock_cnt = lock_cnt;
		case (state)
			csm_pkg::ST_HOLD: begin
				next_lock_cnt = 16'h0000;
				next_state = csm_pkg::ST_ACQ;
			end
			csm_pkg::ST_ACQ: begin
				next_lock_cnt = lock_cnt + 16'h0001;
				if (lock_cnt == 16'(csm_pkg::LOCK_CYCLES - 1)) begin
					next_state = csm_pkg::ST_LOCK;
				end
			end
			csm_pkg::ST_LOCK: begin
				next_lock_cnt = lock_cnt;
			end
			default: begin
				next_state = csm_pkg::ST_HOLD;
			end
		endcase
		if (restart) begin
			next_state = csm_pkg::ST_HOLD;
			next_lock_cnt = 16'h0000;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= csm_pkg::ST_HOLD;
			lock_cnt <= 16'h0000;
		end else if (ce_i) begin
			state <= next_state;
			lock_cnt <= next_lock_cnt;
		end
	end

	// Clock generation; one tap equals one system clock cycle
	assign spread_active = locked && spread_sync;
	// Manager reset also stops the sweep in the cycle before lock drops
	assign spread_hold = !spread_active || mrst_sync;
	// A setting change mid-sweep settles back into the new range within a sweep
	assign taps = $signed({2'b00, ctrl.spread_sel}) + 4'sd1;
	assign period = csm_pkg::NOM_PERIOD + {{4{offset[3]}}, offset};
	assign half = {1'b0, period[7:1]};
	assign quarter = {2'b00, period[7:2]};
	assign period_end = (cnt >= period - 8'h01);

	always_comb begin
		next_cnt = period_end ? 8'h00 : cnt + 8'h01;
		next_offset = offset;
		next_dir_up = dir_up;
		next_div_cnt = div_cnt;
		next_fx_acc = fx_acc + fx_step;
		next_clks = '0;
		// Offset only moves at a period boundary so no short pulse appears
		if (period_end) begin
			next_div_cnt = (div_cnt >= div_ratio - 8'h01) ? 8'h00 : div_cnt + 8'h01;
			if (spread_hold) begin
				next_offset = 4'sd0;
				next_dir_up = 1'b1;
			end else if (dir_up) begin
				if (offset < taps) begin
					next_offset = offset + 4'sd1;
				end else begin
					next_offset = offset - 4'sd1;
					next_dir_up = 1'b0;
				end
			end else begin
				if (offset > -taps) begin
					next_offset = offset - 4'sd1;
				end else begin
					next_offset = offset + 4'sd1;
					next_dir_up = 1'b1;
				end
			end
		end
		if (ctrl.run) begin
			next_clks.phase0 = (cnt < half);
			next_clks.phase180 = !(cnt < half);
			next_clks.div = (div_cnt < {1'b0, div_ratio[7:1]});
			next_clks.fx = fx_acc[15];
			next_clks.fx_inv = !fx_acc[15];
			if (!ctrl.high_freq) begin
				next_clks.phase90 = (cnt >= quarter) && (cnt < quarter + half);
				next_clks.phase270 = !((cnt >= quarter) && (cnt < quarter + half));
				next_clks.dbl = (cnt < quarter) || ((cnt >= half) && (cnt < half + quarter));
				next_clks.dbl_inv = !next_clks.dbl;
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt <= 8'h00;
			offset <= 4'sd0;
			dir_up <= 1'b1;
			div_cnt <= 8'h00;
			fx_acc <= 16'h0000;
			clks <= '0;
		end else if (ce_i) begin
			cnt <= next_cnt;
			offset <= next_offset;
			dir_up <= next_dir_up;
			div_cnt <= next_div_cnt;
			fx_acc <= next_fx_acc;
			clks <= next_clks;
		end
	end

	assign wb_ack_o = ack;
	assign wb_dat_o = rdata;
	assign locked_o = locked;
	assign phase0_clock_out_o = clks.phase0;
	assign phase90_clock_out_o = clks.phase90;
	assign phase180_clock_out_o = clks.phase180;
	assign phase270_clock_out_o = clks.phase270;
	assign double_rate_clock_out_o = clks.dbl;
	assign double_rate_inverted_clock_out_o = clks.dbl_inv;
	assign divided_clock_out_o = clks.div;
	assign synthesized_clock_out_o = clks.fx;
	assign synthesized_inverted_clock_out_o = clks.fx_inv;
endmodule // csm_clock_manager

// file: csm_pkg.sv
// Constants, field layouts and carrier types for the spread-spectrum clock manager
package csm_pkg;
	// Register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	localparam logic [7:0] DIV_OFS = 8'h08;
	localparam logic [7:0] FX_OFS = 8'h0C;
	// Control field positions
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_HF_BIT = 1;
	localparam int CTRL_SPREAD_LSB = 2;
	// Status field positions
	localparam int STAT_LOCK_BIT = 0;
	localparam int STAT_SPREAD_BIT = 1;
	localparam int STAT_HF_BIT = 2;
	localparam int STAT_OFFSET_LSB = 8;
	// Reset values
	localparam logic [3:0] CTRL_RST = 4'h1;
	localparam logic [7:0] DIV_RST = 8'h02;
	localparam logic [15:0] FX_RST = 16'h4000;
	// Timing
	localparam int CLK_MHZ = 10;
	localparam int LOCK_TIME_US = 10;
	localparam int LOCK_CYCLES = LOCK_TIME_US * CLK_MHZ;
	localparam logic [7:0] NOM_PERIOD = 8'h10;
	// Control register carrier
	typedef struct packed {
		logic [1:0] spread_sel;
		logic high_freq;
		logic run;
	} csm_ctrl_t;
	// Generated clock carrier
	typedef struct packed {
		logic phase0;
		logic phase90;
		logic phase180;
		logic phase270;
		logic dbl;
		logic dbl_inv;
		logic div;
		logic fx;
		logic fx_inv;
	} csm_clk_t;
	// Lock sequencer states
	typedef enum logic [2:0] {
		ST_HOLD = 3'b001,
		ST_ACQ = 3'b010,
		ST_LOCK = 3'b100
	} csm_state_t;
endpackage

// file: csm_properties.sv
// Port-level checks for the spread-spectrum clock manager
`timescale 1ns/1ps
module csm_properties (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// Bus and pins
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic mgr_reset_i,
	// Clocks and status
	input wire logic phase0_clock_out_o,
	input wire logic phase90_clock_out_o,
	input wire logic phase180_clock_out_o,
	input wire logic phase270_clock_out_o,
	input wire logic locked_o
);
	logic p0_q;
	logic seen;
	logic [7:0] per;
	logic [7:0] unl;
	wire rise = phase0_clock_out_o & ~p0_q;
	// Saturating counts, so long waits never wrap into a false pass
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			{p0_q, seen, per, unl} <= {2'h0, 8'h00, 8'h00};
		end else begin
			p0_q <= phase0_clock_out_o;
			seen <= seen | rise;
			per <= rise ? 8'h01 : per + {7'h00, per != 8'hff};
			unl <= locked_o ? 8'h00 : unl + {7'h00, unl != 8'hff};
		end
	end
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing");
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	chk_lock_settle: assert property ($rose(locked_o) |-> unl >= csm_pkg::LOCK_CYCLES)
		else $error("lock too early");
	chk_reset_unlock: assert property (mgr_reset_i [*5] |-> !locked_o)
		else $error("locked during reset");
	chk_nominal_period: assert property (rise && seen && unl > 8'h3c |->
		per == csm_pkg::NOM_PERIOD)
		else $error("period spread while unlocked");
	chk_spread_range: assert property (rise && seen |-> per inside {[8'h0c:8'h14]})
		else $error("period out of range");
	chk_quarter_phase: assert property ($rose(phase90_clock_out_o) && unl > 8'h3c |->
		$past(phase0_clock_out_o, 4) && !$past(phase0_clock_out_o, 5))
		else $error("quarter phase wrong");
	chk_half_opposite: assert property (locked_o |-> phase180_clock_out_o != phase0_clock_out_o)
		else $error("half phase wrong");
	chk_quad_excl: assert property (!(phase90_clock_out_o && phase270_clock_out_o))
		else $error("quadrature overlap");
endmodule // csm_properties
bind csm_clock_manager csm_properties i_chk (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .mgr_reset_i(mgr_reset_i),
	.phase0_clock_out_o(phase0_clock_out_o), .phase90_clock_out_o(phase90_clock_out_o),
	.phase180_clock_out_o(phase180_clock_out_o), .phase270_clock_out_o(phase270_clock_out_o),
	.locked_o(locked_o));

// file: csm_user_model.sv
// Clock consumer that records the shortest and longest period of clk_i
`timescale 1ns/1ps
module csm_user_model (
	// Clock and control
	input wire logic sys_clk_i,
	input wire logic clear_i,
	// Observed clock
	input wire logic clk_i,
	// Period extremes
	output logic [7:0] min_o,
	output logic [7:0] max_o
);
	logic last;
	logic seen;
	logic [7:0] cnt;
	// First rise after clear is skipped, its period began unobserved
	always_ff @(posedge sys_clk_i) begin
		last <= clk_i;
		cnt <= (clk_i && !last) ? 8'h01 : cnt + 8'h01;
		if (clear_i) begin
			{min_o, max_o, seen} <= {8'hff, 8'h00, 1'b0};
		end else if (clk_i && !last) begin
			seen <= 1'b1;
			if (seen && cnt < min_o) min_o <= cnt;
			if (seen && cnt > max_o) max_o <= cnt;
		end
	end
endmodule // csm_user_model

// file: test_clock_manager_spread_spectrum.sv
// Self-checking bench for the spread-spectrum clock manager
`timescale 1ns/1ps
module test_clock_manager_spread_spectrum;
	logic sys_clk_i = 0, rst_n_i = 0, cyc = 0, stb = 0, we = 0, pin = 0, mrst = 0, clr = 1;
	logic ack, p0, p90, p270, dbl, dbli, lk, dv, fx, fxi;
	logic [7:0] adr = 0, pmin, pmax, dmin, dmax, fmin, fmax;
	logic [31:0] wdat = 0, dat_o, rd;
	int n_mismatch = 0, samples_checked = 0;
	csm_clock_manager i_dut (.sys_clk_i(sys_clk_i), .ce_i(1'b1), .rst_n_i(rst_n_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
		.wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .spread_enable_in_i(pin),
		.mgr_reset_i(mrst), .phase0_clock_out_o(p0), .phase90_clock_out_o(p90),
		.phase180_clock_out_o(), .phase270_clock_out_o(p270), .double_rate_clock_out_o(dbl),
		.double_rate_inverted_clock_out_o(dbli), .divided_clock_out_o(dv),
		.synthesized_clock_out_o(fx), .synthesized_inverted_clock_out_o(fxi), .locked_o(lk));
	csm_user_model i_usr (.sys_clk_i(sys_clk_i), .clear_i(clr), .clk_i(p0), .min_o(pmin),
		.max_o(pmax));
	csm_user_model i_dvm (.sys_clk_i(sys_clk_i), .clear_i(clr), .clk_i(dv), .min_o(dmin),
		.max_o(dmax));
	csm_user_model i_fxm (.sys_clk_i(sys_clk_i), .clear_i(clr), .clk_i(fx), .min_o(fmin),
		.max_o(fmax));
	initial forever #50 sys_clk_i = ~sys_clk_i;
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk_i);
		{cyc, stb, we, adr, wdat} <= {2'h3, w, a, d};
		@(posedge sys_clk_i);
		while (ack !== 1'b1 && n < 50) begin
			@(posedge sys_clk_i);
			n++;
		end
		rd = dat_o;
		{cyc, stb} <= 2'h0;
		chk(ack, 1'b1, "no ack");
	endtask
	// Lock time is reckoned from the event that restarted the sequencer
	task automatic wait_lock(input time t0, input string m);
		int n;
		n = 0;
		while (lk !== 1'b1 && n < 400) begin
			@(posedge sys_clk_i);
			n++;
		end
		chk(lk, 1'b1, m);
		chk(($time - t0) / 100 >= csm_pkg::LOCK_CYCLES, 1'b1, m);
		chk(($time - t0) / 100 <= csm_pkg::LOCK_CYCLES + 8, 1'b1, m);
	endtask
	task automatic measure(input int cycles);
		clr <= 1'b1;
		@(posedge sys_clk_i);
		clr <= 1'b0;
		repeat (cycles) @(posedge sys_clk_i);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Far longer than the whole sequence, about 10000 cycles
	initial begin
		#1000000;
		n_mismatch++;
		$display("CHECK FAILED %0t timeout", $time);
		give_verdict();
	end
	initial begin
		logic [7:0] ra [5];
		logic [31:0] rv [5];
		time t0;
		ra = '{csm_pkg::CTRL_OFS, csm_pkg::DIV_OFS, csm_pkg::FX_OFS, csm_pkg::STAT_OFS, 8'h10};
		rv = '{{28'h0, csm_pkg::CTRL_RST}, 32'h2, {16'h0, csm_pkg::FX_RST}, 32'h0, 32'h0};
		repeat (20) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		t0 = $time;
		wb(1'b1, csm_pkg::STAT_OFS, 32'hffff_ffff);
		wb(1'b1, 8'h10, 32'hffff_ffff);
		wb(1'b1, csm_pkg::DIV_OFS, 32'h0);
		for (int i = 0; i < 5; i++) begin
			wb(1'b0, ra[i], 32'h0);
			chk(rd, rv[i], "reset value");
		end
		$display("registers done");
		wait_lock(t0, "first lock");
		for (int s = 0; s < 4; s++) begin
			pin <= 1'b0;
			repeat (60) @(posedge sys_clk_i);
			wb(1'b1, csm_pkg::CTRL_OFS, {28'h0, s[1:0], 2'h1});
			pin <= 1'b1;
			repeat (8) @(posedge sys_clk_i);
			measure(500);
			chk({24'h0, pmax}, csm_pkg::NOM_PERIOD + s + 1, "max period");
			chk({24'h0, pmin}, csm_pkg::NOM_PERIOD - s - 1, "min period");
			wb(1'b0, csm_pkg::STAT_OFS, 32'h0);
			chk(rd[2:0], 3'h3, "spread status");
		end
		$display("spread done");
		pin <= 1'b0;
		repeat (60) @(posedge sys_clk_i);
		measure(100);
		chk({pmax, pmin}, {2{csm_pkg::NOM_PERIOD}}, "spread off");
		chk({dmax, dmin}, {2{csm_pkg::NOM_PERIOD << 1}}, "divided period");
		chk({fmax, fmin}, {2{8'(32'h0001_0000 / csm_pkg::FX_RST)}}, "synth period");
		pin <= 1'b1;
		mrst <= 1'b1;
		repeat (40) @(posedge sys_clk_i);
		chk(lk, 1'b0, "lock in reset");
		wb(1'b0, csm_pkg::STAT_OFS, 32'h0);
		chk(rd[1:0], 2'h0, "status in reset");
		mrst <= 1'b0;
		t0 = $time;
		measure(1);
		wait_lock(t0, "relock");
		chk({pmax, pmin}, {2{csm_pkg::NOM_PERIOD}}, "spread before lock");
		repeat (60) @(posedge sys_clk_i);
		wb(1'b0, csm_pkg::STAT_OFS, 32'h0);
		chk(rd[1:0], 2'h3, "spread after lock");
		$display("manager reset done");
		wb(1'b1, csm_pkg::CTRL_OFS, 32'h3);
		t0 = $time;
		repeat (4) @(posedge sys_clk_i);
		repeat (40) begin
			@(posedge sys_clk_i);
			chk({p90, p270, dbl, dbli}, 4'h0, "high mode outputs");
			chk(fxi, !fx, "synth inverse");
		end
		wb(1'b0, csm_pkg::STAT_OFS, 32'h0);
		chk(rd[2], 1'b1, "high mode status");
		wait_lock(t0, "mode relock");
		$display("mode done");
		give_verdict();
	end
endmodule // test_clock_manager_spread_spectrum
